// File: verilog/pec_top.v
// AXI4-Lite register block and wake logic of the pin edge-change interrupt unit.
`include "pec_map.vh"

module pec_top (
  input  wire        clk,
  input  wire        reset_n,
  input  wire [7:0]  porta_pin,
  input  wire [7:0]  portb_pin,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  input  wire [7:0]  s_axi_araddr,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         change_irq_r,
  output reg         change_irq_pending_r
);
  // Reset as released through the two-flop stage.
  reg  [1:0]  rst_sync_r;
  wire        rst_n;

  // Software-visible enables, master enable and sticky flags.
  reg  [7:0]  porta_rise_enable;
  reg  [7:0]  porta_fall_enable;
  reg  [7:0]  portb_rise_enable;
  reg  [7:0]  portb_fall_enable;
  reg         change_irq_master_enable;
  wire [7:0]  porta_change_flags;
  wire [7:0]  portb_change_flags;

  // Synchronised pin samples, current and one clock older.
  wire [7:0]  pa_cur;
  wire [7:0]  pa_prev;
  wire [7:0]  pb_cur;
  wire [7:0]  pb_prev;

  // Write channel capture; address and data may arrive in either order.
  reg         aw_held_r;
  reg  [7:0]  aw_addr_r;
  reg         w_held_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  wire        wr_go;
  wire        wr_lane0;
  wire        pending_nxt;

  // Committed-write decodes.
  wire        wr_pa_flags;
  wire        wr_pb_flags;
  wire        wr_ctrl;

  // Reset is asserted at once and released through two flops.
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // Returns the implemented-bit mask for a register offset, zero when unmapped.
  function [7:0] reg_mask;
    input [7:0] a;
    begin
      case (a)
        `PEC_OFF_PA_RISE:   reg_mask = `PEC_PA_MASK;
        `PEC_OFF_PA_FALL:   reg_mask = `PEC_PA_MASK;
        `PEC_OFF_PA_FLAGS:  reg_mask = `PEC_PA_MASK;
        `PEC_OFF_PB_RISE:   reg_mask = `PEC_PB_MASK;
        `PEC_OFF_PB_FALL:   reg_mask = `PEC_PB_MASK;
        `PEC_OFF_PB_FLAGS:  reg_mask = `PEC_PB_MASK;
        `PEC_OFF_CORE_CTRL: reg_mask = `PEC_CTRL_MASK;
        default:            reg_mask = 8'h00;
      endcase
    end
  endfunction

  // True for any offset in the map, used for the error response.
  function is_mapped;
    input [7:0] a;
    begin
      case (a)
        `PEC_OFF_PA_RISE, `PEC_OFF_PA_FALL, `PEC_OFF_PA_FLAGS,
        `PEC_OFF_PB_RISE, `PEC_OFF_PB_FALL, `PEC_OFF_PB_FLAGS,
        `PEC_OFF_CORE_CTRL: is_mapped = 1'b1;
        default:            is_mapped = 1'b0;
      endcase
    end
  endfunction

  // True when a committed write with byte lane 0 enabled lands on offset o.
  function wr_hit;
    input       go;
    input       lane0;
    input [7:0] a;
    input [7:0] o;
    begin
      wr_hit = go && lane0 && (a == o);
    end
  endfunction

  // Pin sampling; the edge stage compares cur against prev.
  pec_sync #(.W(8)) u_sync_a (
    .clk    (clk),
    .rst_n  (rst_n),
    .pin_in (porta_pin),
    .cur_r  (pa_cur),
    .prev_r (pa_prev)
  );

  pec_sync #(.W(8)) u_sync_b (
    .clk    (clk),
    .rst_n  (rst_n),
    .pin_in (portb_pin),
    .cur_r  (pb_cur),
    .prev_r (pb_prev)
  );

  // Port A detectors; the mask drops bits 7, 6 and 2.
  pec_edge u_edge_a (
    .clk       (clk),
    .rst_n     (rst_n),
    .impl_mask (`PEC_PA_MASK),
    .cur       (pa_cur),
    .prev      (pa_prev),
    .rise_en   (porta_rise_enable),
    .fall_en   (porta_fall_enable),
    .wr_flags  (wr_pa_flags),
    .wr_data   (w_data_r[7:0]),
    .flags_r   (porta_change_flags)
  );

  // Port B detectors; only the upper nibble exists.
  pec_edge u_edge_b (
    .clk       (clk),
    .rst_n     (rst_n),
    .impl_mask (`PEC_PB_MASK),
    .cur       (pb_cur),
    .prev      (pb_prev),
    .rise_en   (portb_rise_enable),
    .fall_en   (portb_fall_enable),
    .wr_flags  (wr_pb_flags),
    .wr_data   (w_data_r[7:0]),
    .flags_r   (portb_change_flags)
  );

  // Address and data are captured independently, so either may come first.
  assign wr_go    = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_lane0 = w_strb_r[0];

  // Committed-write decodes shared by the flag stages and the control register.
  assign wr_pa_flags = wr_hit(wr_go, wr_lane0, aw_addr_r, `PEC_OFF_PA_FLAGS);
  assign wr_pb_flags = wr_hit(wr_go, wr_lane0, aw_addr_r, `PEC_OFF_PB_FLAGS);
  assign wr_ctrl     = wr_hit(wr_go, wr_lane0, aw_addr_r, `PEC_OFF_CORE_CTRL);

  // Write address channel; ready is a one-cycle pulse held off while an address is held, so a held address is never overwritten by a
  // second request before its data have arrived.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held_r     <= 1'b0;
      aw_addr_r     <= 8'h00;
      s_axi_awready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (wr_go)
        aw_held_r <= 1'b0;
    end
  end

  // Write data channel, captured on its own handshake.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      w_held_r     <= 1'b0;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_wready <= !w_held_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go)
        w_held_r <= 1'b0;
    end
  end

  // Write response; raised once both halves are held and dropped when the master takes it.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PEC_RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= is_mapped(aw_addr_r) ? `PEC_RESP_OKAY : `PEC_RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Enable registers; only implemented bits store, the rest stay zero.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      porta_rise_enable        <= `PEC_RST_BYTE;
      porta_fall_enable        <= `PEC_RST_BYTE;
      portb_rise_enable        <= `PEC_RST_BYTE;
      portb_fall_enable        <= `PEC_RST_BYTE;
    end
    else if (wr_go && wr_lane0)
    begin
      case (aw_addr_r)
        `PEC_OFF_PA_RISE: porta_rise_enable <= w_data_r[7:0] & reg_mask(aw_addr_r);
        `PEC_OFF_PA_FALL: porta_fall_enable <= w_data_r[7:0] & reg_mask(aw_addr_r);
        `PEC_OFF_PB_RISE: portb_rise_enable <= w_data_r[7:0] & reg_mask(aw_addr_r);
        `PEC_OFF_PB_FALL: portb_fall_enable <= w_data_r[7:0] & reg_mask(aw_addr_r);
        default:          porta_rise_enable <= porta_rise_enable;
      endcase
    end
  end

  // Master enable in the core control word; the pending bit beside it is read-only, so a write
  // cannot fake a pending interrupt.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      change_irq_master_enable <= 1'b0;
    else if (wr_ctrl)
      change_irq_master_enable <= w_data_r[`PEC_CTRL_MEN_BIT];
  end

  // Read address ready is a one-cycle pulse, held off while an answer still stands so that a second
  // address cannot replace the one being answered.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_axi_arready <= 1'b0;
    else
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
  end

  // Read path: one cycle after the address is taken, data appear with rvalid.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PEC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= is_mapped(s_axi_araddr) ? `PEC_RESP_OKAY : `PEC_RESP_SLVERR;
        case (s_axi_araddr)
          `PEC_OFF_PA_RISE:   s_axi_rdata <= {24'h000000, porta_rise_enable};
          `PEC_OFF_PA_FALL:   s_axi_rdata <= {24'h000000, porta_fall_enable};
          `PEC_OFF_PA_FLAGS:  s_axi_rdata <= {24'h000000, porta_change_flags};
          `PEC_OFF_PB_RISE:   s_axi_rdata <= {24'h000000, portb_rise_enable};
          `PEC_OFF_PB_FALL:   s_axi_rdata <= {24'h000000, portb_fall_enable};
          `PEC_OFF_PB_FLAGS:  s_axi_rdata <= {24'h000000, portb_change_flags};
          `PEC_OFF_CORE_CTRL: s_axi_rdata <= {28'h0000000, change_irq_master_enable, 2'b00,
                                              change_irq_pending_r};
          default:            s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Pending follows flags one cycle later; the wake request never precedes its flag.
  assign pending_nxt = |{porta_change_flags, portb_change_flags};

  // The combined bit that software reads; it trails the flags by one clock.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      change_irq_pending_r <= 1'b0;
    else
      change_irq_pending_r <= pending_nxt;
  end

  // Wake request, built from the same OR as pending so it can never lead a flag; gating it here rather
  // than at the flags keeps edges recorded while the master enable is off.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      change_irq_r <= 1'b0;
    else
      change_irq_r <= pending_nxt & change_irq_master_enable;
  end
endmodule

// File: common/pec_map.vh
// Register offsets, field layouts and reset values of the pin edge-change interrupt unit.
`ifndef PEC_MAP_VH
`define PEC_MAP_VH
`define PEC_OFF_PA_RISE     8'h00
`define PEC_OFF_PA_FALL     8'h04
`define PEC_OFF_PA_FLAGS    8'h08
`define PEC_OFF_PB_RISE     8'h0C
`define PEC_OFF_PB_FALL     8'h10
`define PEC_OFF_PB_FLAGS    8'h14
`define PEC_OFF_CORE_CTRL   8'h18
`define PEC_PA_MASK         8'h3B
`define PEC_PB_MASK         8'hF0
`define PEC_CTRL_MEN_BIT    3
`define PEC_CTRL_PEND_BIT   0
`define PEC_CTRL_MASK       8'h08
`define PEC_RST_BYTE        8'h00
`define PEC_RESP_OKAY       2'h0
`define PEC_RESP_SLVERR     2'h2
`endif

// File: verilog/pec_sync.v
// Two-stage synchroniser for a vector of pin levels followed by a previous-sample stage.
module pec_sync #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] cur_r,
  output reg  [W-1:0] prev_r
);
  reg [W-1:0] meta_r;

  // The first stage feeds only the second; edges are judged between cur_r and prev_r.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= {W{1'b0}};
      cur_r  <= {W{1'b0}};
      prev_r <= {W{1'b0}};
    end
    else
    begin
      meta_r <= pin_in;
      cur_r  <= meta_r;
      prev_r <= cur_r;
    end
  end
endmodule

// File: verilog/pec_edge.v
// Per-port edge detector: sticky change flags with set-over-clear priority.
module pec_edge (
  input  wire       clk,
  input  wire       rst_n,
  input  wire [7:0] impl_mask,
  input  wire [7:0] cur,
  input  wire [7:0] prev,
  input  wire [7:0] rise_en,
  input  wire [7:0] fall_en,
  input  wire       wr_flags,
  input  wire [7:0] wr_data,
  output reg  [7:0] flags_r
);
  wire [7:0] hit;
  wire [7:0] flags_nxt;

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_bit
      // Rising edge armed by rise_en, falling edge armed by fall_en.
      assign hit[i] = impl_mask[i] & ((rise_en[i] & cur[i] & ~prev[i]) |
                                      (fall_en[i] & ~cur[i] & prev[i]));
      // A write only clears or keeps; a fresh edge in the same cycle wins.
      assign flags_nxt[i] = impl_mask[i] & (hit[i] | (wr_flags ? (wr_data[i] & flags_r[i]) : flags_r[i]));
    end
  endgenerate

  // Flags are sticky until software writes zero.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flags_r <= 8'h00;
    else
      flags_r <= flags_nxt;
  end
endmodule

// File: verif/pec_pins.sv
// Behavioural model of the external pins that feed the edge-change unit.
module pec_pins (
  input  wire        clk,
  input  wire  [7:0] a_req,
  input  wire  [7:0] b_req,
  output logic [7:0] porta_pin,
  output logic [7:0] portb_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins start low so that no edge is seen before the enables are set.
  initial
  begin
    porta_pin = 8'h00;
    portb_pin = 8'h00;
  end
  // Levels move just after an edge of the same clk that the unit uses; its sampling stage still resynchronises them.
  always @(posedge clk)
  begin
    porta_pin <= a_req;
    portb_pin <= b_req;
  end
endmodule

// File: verif/pec_chk_sva.sv
// Port-level assertions of the pin edge-change interrupt unit.
module pec_chk (
  input wire        clk,
  input wire        reset_n,
  input wire [7:0]  porta_pin,
  input wire [7:0]  portb_pin,
  input wire        s_axi_awready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        change_irq_r,
  input wire        change_irq_pending_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // A read of the first unmapped word.
  sequence s_ar_bad;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h1C;
  endsequence
  // The pins moved a few cycles earlier, as the sync and compare stages need.
  sequence s_pin_moved;
    $past({porta_pin, portb_pin}, 3) != $past({porta_pin, portb_pin}, 4)
    || $past({porta_pin, portb_pin}, 4) != $past({porta_pin, portb_pin}, 5)
    || $past({porta_pin, portb_pin}, 5) != $past({porta_pin, portb_pin}, 6);
  endsequence
  a_irq_gated: assert property (change_irq_r |-> change_irq_pending_r)
    else $error("request without pending flag");
  a_pend_cause: assert property ($rose(change_irq_pending_r) |-> s_pin_moved)
    else $error("pending rose without a pin edge");
  a_pend_sticky: assert property ($fell(change_irq_pending_r) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("pending fell without a write");
  a_first_edge: assert property ($rose(reset_n) |-> !change_irq_pending_r && !change_irq_r)
    else $error("outputs set after reset");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_rd_refused: assert property (s_ar_bad |=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read answered wrongly");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready held");
  a_rd_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_wr_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
endmodule
bind pec_top pec_chk pec_chk_i (.clk, .reset_n, .porta_pin, .portb_pin, .s_axi_awready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_rresp, .change_irq_r, .change_irq_pending_r);

// File: verif/tb.sv
// Self-checking bench of the pin edge-change interrupt unit.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'h0;
  logic        reset_n = 1'h0;
  logic [7:0]  a_req = 8'h00;
  logic [7:0]  b_req = 8'h00;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  wire  [7:0]  porta_pin, portb_pin;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         change_irq_r, change_irq_pending_r;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  int          err_total = 0;
  int          compares = 0;
  logic [31:0] rv;
  logic [1:0]  rsp;
  // Address, written byte, expected read-back; the control row is last so the master enable ends set.
  logic [23:0] rows [0:6] = '{24'h00FF3B, 24'h04FF3B, 24'h0CFFF0, 24'h10FFF0, 24'h08FF00, 24'h14FF00, 24'h18FF08};
  pec_top pec_top_i (.clk, .reset_n, .porta_pin, .portb_pin, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .change_irq_r, .change_irq_pending_r);
  pec_pins pec_pins_i (.clk, .a_req, .b_req, .porta_pin, .portb_pin);
  initial forever #25 clk = ~clk;
  task chk(input logic [31:0] s, input logic [31:0] e);
  begin
    compares++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  end
  endtask
  // Each channel is released only at the edge where its ready is seen.
  task wr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(posedge clk);
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hF;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (s_axi_bvalid !== 1'h1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  end
  endtask
  task rd(input logic [7:0] a);
  begin
    @(posedge clk);
    s_axi_arvalid <= 1'h1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (s_axi_rvalid !== 1'h1);
    rv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  end
  endtask
  task rc(input logic [7:0] a, input logic [7:0] e);
  begin
    rd(a);
    chk(rv, {24'h0, e});
  end
  endtask
  // The pin path needs three edges; eight leaves margin for the pending stage.
  task pw;
    repeat (8) @(posedge clk);
  endtask
  task end_of_test;
  begin
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    end_of_test;
  end
  initial
  begin
    repeat (16) @(posedge clk);
    reset_n <= 1'h1;
    repeat (3) @(posedge clk);
    foreach (rows[i])
    begin
      rc(rows[i][23:16], 8'h00);
      wr(rows[i][23:16], rows[i][15:8]);
      rc(rows[i][23:16], rows[i][7:0]);
    end
    // A rise on bit 0 flags; the unused bit 2 moving alongside must not.
    a_req <= 8'h05;
    pw;
    rc(8'h08, 8'h01);
    chk({31'h0, change_irq_r}, 32'h1);
    chk({31'h0, change_irq_pending_r}, 32'h1);
    // Clear by masking in the inverse of the flags just read.
    rd(8'h08);
    wr(8'h08, rv[7:0] ^ 8'hFF);
    rc(8'h08, 8'h00);
    pw;
    chk({31'h0, change_irq_pending_r}, 32'h0);
    // Port B with rise detection off: only the fall may flag.
    wr(8'h0C, 8'h00);
    b_req <= 8'h80;
    pw;
    rc(8'h14, 8'h00);
    b_req <= 8'h00;
    pw;
    rc(8'h14, 8'h80);
    // Master enable off: flags still set, request stays low.
    wr(8'h18, 8'h00);
    a_req <= 8'h04;
    pw;
    rc(8'h08, 8'h01);
    chk({31'h0, change_irq_r}, 32'h0);
    rc(8'h18, 8'h01);
    // A rise on bit 3 lands in the very cycle the clearing write commits; the edge must win.
    a_req <= 8'h0C;
    wr(8'h08, 8'h00);
    rc(8'h08, 8'h08);
    // Unmapped word is refused both ways.
    rc(8'h1C, 8'h00);
    chk({30'h0, rsp}, 32'h2);
    wr(8'h1C, 8'hFF);
    chk({30'h0, rsp}, 32'h2);
    // A reset in mid-run clears every flag and enable.
    reset_n <= 1'h0;
    repeat (2) @(posedge clk);
    reset_n <= 1'h1;
    repeat (3) @(posedge clk);
    rc(8'h14, 8'h00);
    rc(8'h00, 8'h00);
    chk({31'h0, change_irq_pending_r}, 32'h0);
    end_of_test;
  end
endmodule
